// File: hw/hsc_pkg.sv
// package: high-speed counter constants, register map and carriers
package hsc_pkg;
   // =========================================================
   // timing
   localparam int CLK_NS    = 8;               // 125 MHz clock
   localparam int US_NS     = 1000;            // one microsecond
   localparam int US_CYC    = US_NS / CLK_NS;  // cycles per us
   localparam int Q_NS      = 250;             // 0.25 us tick
   localparam int Q_CYC     = Q_NS / CLK_NS;   // period, rounded down
   localparam int US_PER_MS = 1000;            // hold time unit
   localparam int TEN_US    = 10;              // 10 us tick
   localparam int HUND_US   = 100;             // 100 us tick
   // filter time constants: a/b/z in ns, control in us
   localparam int AB_NS [6] = '{100, 200, 500, 1000, 2000, 10000};
   localparam int CT_US [12] = '{0, 2, 5, 10, 20, 50, 100, 500,
                                 1000, 2000, 5000, 10000};
   localparam int AB_MAX = 5;
   localparam int CT_MAX = 11;
   // =========================================================
   // register byte offsets
   localparam logic [11:0] A_CTRL  = 12'h000;  // mode bits
   localparam logic [11:0] A_FILT  = 12'h004;  // filter selects
   localparam logic [11:0] A_UPPER = 12'h008;  // counter upper limit
   localparam logic [11:0] A_LOWER = 12'h00C;  // counter lower limit
   localparam logic [11:0] A_DFLT  = 12'h010;  // default/preset value
   localparam logic [11:0] A_COUNT = 12'h014;  // count value
   localparam logic [11:0] A_STAT  = 12'h018;  // flags, ovf, outputs
   localparam logic [11:0] A_MRST  = 12'h01C;  // match edge resets
   localparam logic [11:0] A_OSEL  = 12'h020;  // output flag select
   localparam logic [11:0] A_HOLD  = 12'h024;  // output hold, ms
   localparam logic [11:0] A_BANDON = 12'h028; // in-band flag states
   localparam logic [11:0] A_CAP   = 12'h02C;  // capture trigger
   localparam logic [11:0] A_CAPV  = 12'h030;  // captured count
   localparam logic [2:0]  TBL_HI  = 3'h1;     // table at 0x200
   // =========================================================
   // control field positions
   localparam int F_RING = 0;
   localparam int F_OVF  = 1;
   localparam int F_REV  = 2;
   localparam int F_SRC  = 3;   // 3 bits
   localparam int F_METH = 6;   // 3 bits
   localparam int F_ZF   = 9;   // 4 bits
   localparam int F_C0   = 13;  // 3 bits
   localparam int F_C1   = 16;  // 2 bits
   localparam int F_MODE = 18;  // 2 bits
   localparam int F_NCMP = 20;  // 4 bits, entries minus one
   localparam int F_OE   = 24;  // 2 bits
   localparam int F_ZS   = 3;   // filter: z select
   localparam int F_CS   = 6;   // filter: control select
   localparam int F_H1   = 16;  // hold: output 1
   // compare modes
   localparam logic [1:0] MD_BAND = 2'h1;
   localparam logic [1:0] MD_TGT  = 2'h2;
   // reset values
   localparam logic [31:0] CTRL_RST  = 32'(4'hF) << F_NCMP;
   localparam logic [31:0] FILT_RST  = 32'h4 | (32'h5 << F_ZS)
                                       | (32'h9 << F_CS);
   localparam logic [31:0] UPPER_RST = 32'h7FFF_FFFF;
   localparam logic [31:0] LOWER_RST = 32'h8000_0000;
   // =========================================================
   // decode methods
   typedef enum logic [2:0] {
      M_P1, M_P2, M_P4, M_I1, M_I2, M_D1, M_D2
   } hsc_meth_type;
   // input pins, a at bit 0
   typedef struct packed {
      logic c1, c0, z, b, a;
   } hsc_pins_type;
   // whole module state
   typedef struct packed {
      logic [4:0]        s1, s2, flt, prv;
      logic [4:0][13:0]  fc;
      logic [6:0]        usd, usc;
      logic [4:0]        qd;
      logic [31:0]       ctrl, filt, upper, lower, dflt, count;
      logic [31:0]       mrst, osel, hold, capv;
      logic [15:0]       bandon, flags, flags_p;
      logic [2:0]        capsel;
      logic              ovf, udf;
      logic [1:0][19:0]  hc;
      logic [1:0]        xo;
      logic [15:0][31:0] lo, up, tg, pu, pd;
      logic              act, wr;
      logic [11:0]       ad;
      logic [31:0]       rd;
   } hsc_st_type;
   // ns to cycles, rounded up
   function automatic int ns2cyc(input int ns);
      return (ns + CLK_NS - 1) / CLK_NS;
   endfunction
endpackage

// File: hw/hsc_top.sv
// module: high-speed counter channel with AHB-Lite register slave
// Notes on behaviour
// - band flags follow 16 limit pairs
// - 16 targets set/reset flags per direction
// - two outputs follow selected match flags
// - band mode holds output on, up to 1000ms
// - separate noise filters on inputs, controls
// - linear or ring, limits, optional overflow
// - reverse direction swaps up and down
// - count pins or internal 0.25-100us ticks
// - seven decode methods, two-phase x1 default
// - z resets or presets on edge/level
// - control 0 enables, optional reset/preset
// - control 1 is enable only
// - count loads default value at power-up
// - a/b filter 0.1 to 10us, 2us default
// - z filter same, plus no filter
// - control filter up to 10ms, 2ms default
// - no capture from enable-assigned control
// - match flag edge may reset count
// - signed 32-bit count value
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns
module hsc_top (
   // clock and reset
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                ce,
   // ahb-lite slave
   input  wire logic                hsel,
   input  wire logic [31:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic                     hreadyout,
   output logic [31:0]              hrdata,
   output logic                     hresp,
   // encoder and control pins
   input  wire hsc_pkg::hsc_pins_type pins,
   // external outputs
   output logic [1:0]               ext_out
);
   import hsc_pkg::*;

   // =========================================================
   // state
   localparam hsc_st_type ST_RST = '{ctrl: CTRL_RST, filt: FILT_RST,
      upper: UPPER_RST, lower: LOWER_RST, default: '0};
   hsc_st_type r, n;        // registered state and next
   logic [13:0] lim [5];    // filter limits per input
   logic        ust, itk;   // us tick, internal count tick
   logic        inc, dec;   // decoded count events
   logic        en, do_up, do_dn;
   logic        zr, zp, cr, cp, mr; // reset/preset sources
   logic        kill;       // step overridden this cycle
   logic [4:0]  ri, fa;     // filtered rising, falling edges

   // table hit: 16 entries of 32 bytes at 0x200
   function automatic logic tbl(input logic [11:0] a);
      return a[11:9] == TBL_HI && a[4:2] < 3'h5;
   endfunction

   // read mux, sampled in the address phase
   function automatic logic [31:0] rdval(input logic [11:0] a);
      logic [31:0] v;
      v = '0;
      if (tbl(a)) begin
         case (a[4:2])
            3'h0:    v = r.lo[a[8:5]];
            3'h1:    v = r.up[a[8:5]];
            3'h2:    v = r.tg[a[8:5]];
            3'h3:    v = r.pu[a[8:5]];
            default: v = r.pd[a[8:5]];
         endcase
      end else begin
         case (a)
            A_CTRL:   v = r.ctrl;
            A_FILT:   v = r.filt;
            A_UPPER:  v = r.upper;
            A_LOWER:  v = r.lower;
            A_DFLT:   v = r.dflt;
            A_COUNT:  v = r.count;
            A_STAT:   v = {12'h0, r.xo, r.udf, r.ovf, r.flags};
            A_MRST:   v = r.mrst;
            A_OSEL:   v = r.osel;
            A_HOLD:   v = r.hold;
            A_BANDON: v = {16'h0, r.bandon};
            A_CAP:    v = {29'h0, r.capsel};
            A_CAPV:   v = r.capv;
            default:  v = '0;  // unmapped reads as zero
         endcase
      end
      return v;
   endfunction

   // ahb answers: zero wait, stalled while frozen, always OKAY
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign hrdata    = r.rd;
   assign ext_out   = r.xo;

   // =========================================================
   // next-state logic
   always_comb begin
      logic a, b, pa, pb, chg;
      logic [3:0] sel;
      logic       f, ins, ov_ev, un_ev;
      logic [2:0] ab, zs;
      logic [3:0] cs;
      a = 1'b0; b = 1'b0; pa = 1'b0; pb = 1'b0; chg = 1'b0;
      sel = '0; f = 1'b0; ins = 1'b0;
      ab = '0; zs = '0; cs = '0; ov_ev = 1'b0; un_ev = 1'b0;
      n = r;
      // pins pass two flops before use
      n.s1 = pins;
      n.s2 = r.s1;
      // time bases: microsecond and quarter-microsecond
      ust = r.usd == 7'(US_CYC - 1);
      n.usd = ust ? 7'h0 : r.usd + 7'h1;
      if (ust)
         n.usc = (r.usc == 7'(HUND_US - 1)) ? 7'h0 : r.usc + 7'h1;
      n.qd = (r.qd == 5'(Q_CYC - 1)) ? 5'h0 : r.qd + 5'h1;
      case (r.ctrl[F_SRC +: 3])
         3'h1:    itk = r.qd == 5'(Q_CYC - 1);
         3'h2:    itk = ust;
         3'h3:    itk = ust && (r.usc % 7'(TEN_US)) == 7'(TEN_US - 1);
         3'h4:    itk = ust && r.usc == 7'(HUND_US - 1);
         default: itk = 1'b0;
      endcase
      // filter limits; a/b/z in cycles, controls in us ticks
      ab = (r.filt[2:0] > 3'(AB_MAX)) ? 3'(AB_MAX) : r.filt[2:0];
      zs = (r.filt[F_ZS +: 3] > 3'(AB_MAX + 1)) ? 3'(AB_MAX + 1)
           : r.filt[F_ZS +: 3];
      cs = (r.filt[F_CS +: 4] > 4'(CT_MAX)) ? 4'(CT_MAX)
           : r.filt[F_CS +: 4];
      lim[0] = 14'(ns2cyc(AB_NS[ab]));
      lim[1] = lim[0];
      lim[2] = (zs == 3'h0) ? 14'h0 : 14'(ns2cyc(AB_NS[zs - 3'h1]));
      lim[3] = 14'(CT_US[cs]);
      lim[4] = lim[3];
      // a change is accepted once it has stood for the limit
      for (int i = 0; i < 5; i++) begin
         if (r.s2[i] == r.flt[i]) begin
            n.fc[i] = '0;
         end else if (lim[i] == 14'h0) begin
            n.flt[i] = r.s2[i];
         end else if (i < 3 || ust) begin
            if (r.fc[i] + 14'h1 >= lim[i]) begin
               n.flt[i] = r.s2[i];
               n.fc[i]  = '0;
            end else begin
               n.fc[i] = r.fc[i] + 14'h1;
            end
         end
      end
      n.prv = r.flt;
      ri = r.flt & ~r.prv;
      fa = ~r.flt & r.prv;
      // decode count pins
      a = r.flt[0]; b = r.flt[1]; pa = r.prv[0]; pb = r.prv[1];
      chg = (a ^ pa) ^ (b ^ pb);
      case (hsc_meth_type'(r.ctrl[F_METH +: 3]))
         M_P1: begin
            inc = ri[0] & ~b;
            dec = fa[0] & ~b;
         end
         M_P2: begin
            inc = (ri[0] & ~b) | (fa[0] & b);
            dec = (ri[0] & b) | (fa[0] & ~b);
         end
         M_P4: begin
            inc = chg & (a ^ pb);
            dec = chg & ~(a ^ pb);
         end
         M_I1: begin
            inc = ri[0];
            dec = ri[1];
         end
         M_I2: begin
            inc = ri[0] | fa[0];
            dec = ri[1] | fa[1];
         end
         M_D1: begin
            inc = ri[0] & ~b;
            dec = ri[0] & b;
         end
         M_D2: begin
            inc = (ri[0] | fa[0]) & ~b;
            dec = (ri[0] | fa[0]) & b;
         end
         default: begin
            inc = 1'b0;
            dec = 1'b0;
         end
      endcase
      if (r.ctrl[F_SRC +: 3] != 3'h0) begin
         inc = itk;
         dec = 1'b0;
      end
      if (r.ctrl[F_REV]) begin
         {inc, dec} = {dec, inc};
      end
      // enables: control 0 and control 1
      case (r.ctrl[F_C0 +: 3])
         3'h1, 3'h3, 3'h5: en = r.flt[3];
         3'h2, 3'h4, 3'h6: en = ~r.flt[3];
         default:          en = 1'b1;
      endcase
      case (r.ctrl[F_C1 +: 2])
         2'h1:    en = en & r.flt[4];
         2'h2:    en = en & ~r.flt[4];
         default: en = en;
      endcase
      cr = (r.ctrl[F_C0 +: 3] == 3'h3 && ri[3])
           || (r.ctrl[F_C0 +: 3] == 3'h4 && fa[3]);
      cp = (r.ctrl[F_C0 +: 3] == 3'h5 && ri[3])
           || (r.ctrl[F_C0 +: 3] == 3'h6 && fa[3]);
      // z: edge or level triggered reset/preset
      case (r.ctrl[F_ZF +: 4])
         4'h1, 4'h5: f = ri[2];
         4'h2, 4'h6: f = fa[2];
         4'h3, 4'h7: f = r.flt[2];
         4'h4, 4'h8: f = ~r.flt[2];
         default:    f = 1'b0;
      endcase
      zr = f && r.ctrl[F_ZF +: 4] <= 4'h4;
      zp = f && r.ctrl[F_ZF +: 4] > 4'h4;
      mr = |((r.flags & ~r.flags_p & r.mrst[15:0])
           | (~r.flags & r.flags_p & r.mrst[31:16]));
      kill = zr | zp | cr | cp | mr;
      do_up = en & inc & ~dec;
      do_dn = en & dec & ~inc;
      // step with ring wrap or linear stop
      if (do_up) begin
         if ($signed(r.count) >= $signed(r.upper)) begin
            if (r.ctrl[F_RING])
               n.count = r.lower;
            else if (r.ctrl[F_OVF])
               ov_ev = 1'b1;
         end else begin
            n.count = r.count + 32'h1;
         end
      end else if (do_dn) begin
         if ($signed(r.count) <= $signed(r.lower)) begin
            if (r.ctrl[F_RING])
               n.count = r.upper;
            else if (r.ctrl[F_OVF])
               un_ev = 1'b1;
         end else begin
            n.count = r.count - 32'h1;
         end
      end
      // sticky limit flags; an event in a clear cycle still sets them
      n.ovf = r.ovf | ov_ev;
      n.udf = r.udf | un_ev;
      if (zp | cp)
         n.count = r.dflt;
      if (zr | cr | mr)
         n.count = '0;
      // comparison
      n.flags_p = r.flags;
      if (r.ctrl[F_MODE +: 2] == MD_BAND) begin
         for (int i = 0; i < 16; i++) begin
            if ($signed(r.lo[i]) <= $signed(r.up[i]))
               ins = $signed(r.count) >= $signed(r.lo[i])
                     && $signed(r.count) <= $signed(r.up[i]);
            else
               ins = $signed(r.count) >= $signed(r.lo[i])
                     || $signed(r.count) <= $signed(r.up[i]);
            n.flags[i] = (4'(i) <= r.ctrl[F_NCMP +: 4])
                         && (ins == r.bandon[i]);
         end
      end else if (r.ctrl[F_MODE +: 2] == MD_TGT) begin
         for (int i = 0; i < 16; i++) begin
            if (4'(i) <= r.ctrl[F_NCMP +: 4] && !kill
                && (do_up || do_dn) && n.count == r.tg[i]) begin
               if (do_up)
                  n.flags = (n.flags | r.pu[i][15:0]) & ~r.pu[i][31:16];
               else
                  n.flags = (n.flags | r.pd[i][15:0]) & ~r.pd[i][31:16];
            end
         end
      end else begin
         n.flags = '0;
      end
      // external outputs; hold only in band mode
      for (int k = 0; k < 2; k++) begin
         sel = r.osel[4 * k +: 4];
         f = r.flags[sel];
         if (!r.ctrl[F_OE + k]) begin
            n.xo[k] = 1'b0;
            n.hc[k] = '0;
         end else if (r.ctrl[F_MODE +: 2] == MD_BAND) begin
            if (f && !r.xo[k])
               n.hc[k] = 20'(r.hold[F_H1 * k +: 10] * US_PER_MS);
            else if (ust && r.hc[k] != 20'h0)
               n.hc[k] = r.hc[k] - 20'h1;
            n.xo[k] = f || r.hc[k] != 20'h0;
         end else begin
            n.xo[k] = f;
            n.hc[k] = '0;
         end
      end
      // capture, refused on an enable-assigned control
      case (r.capsel)
         3'h1: f = ri[3] && r.ctrl[F_C0 +: 3] == 3'h0;
         3'h2: f = fa[3] && r.ctrl[F_C0 +: 3] == 3'h0;
         3'h3: f = ri[4] && r.ctrl[F_C1 +: 2] == 2'h0;
         3'h4: f = fa[4] && r.ctrl[F_C1 +: 2] == 2'h0;
         default: f = 1'b0;
      endcase
      if (f)
         n.capv = r.count;
      // ahb address phase: word transfers only
      n.act = hsel && htrans[1] && hready && hsize == 3'h2;
      n.wr  = hwrite;
      n.ad  = {haddr[11:2], 2'b00};
      if (n.act && !hwrite)
         n.rd = rdval(n.ad);
      // ahb data phase write
      if (r.act && r.wr) begin
         if (tbl(r.ad)) begin
            case (r.ad[4:2])
               3'h0:    n.lo[r.ad[8:5]] = hwdata;
               3'h1:    n.up[r.ad[8:5]] = hwdata;
               3'h2:    n.tg[r.ad[8:5]] = hwdata;
               3'h3:    n.pu[r.ad[8:5]] = hwdata;
               default: n.pd[r.ad[8:5]] = hwdata;
            endcase
         end else begin
            case (r.ad)
               A_CTRL:   n.ctrl = hwdata;
               A_FILT:   n.filt = hwdata;
               A_UPPER:  n.upper = hwdata;
               A_LOWER:  n.lower = hwdata;
               A_DFLT:   n.dflt = hwdata;
               A_COUNT:  n.count = hwdata;
               A_STAT: begin  // write one clears; a new event wins
                  n.ovf = ov_ev | (r.ovf & ~hwdata[16]);
                  n.udf = un_ev | (r.udf & ~hwdata[17]);
               end
               A_MRST:   n.mrst = hwdata;
               A_OSEL:   n.osel = hwdata;
               A_HOLD:   n.hold = hwdata;
               A_BANDON: n.bandon = hwdata[15:0];
               A_CAP:    n.capsel = hwdata[2:0];
               default:  n = n;  // unmapped write ignored
            endcase
         end
      end
   end

   // state register; count resets to the default value of zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         r <= ST_RST;
      else if (ce)
         r <= n;
   end

   // =========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   logic bus_cw;  // count written by the bus this cycle
   assign bus_cw = r.act && r.wr && r.ad == A_COUNT;

   sequence s_step_top;
      ce && do_up && !kill && !bus_cw
      && $signed(r.count) >= $signed(r.upper);
   endsequence

   AST_RING_WRAP: assert property (
      s_step_top ##0 r.ctrl[F_RING] |=> r.count == $past(r.lower))
      else $error("ring counter did not wrap to lower limit");
   AST_LIN_STOP: assert property (
      s_step_top ##0 !r.ctrl[F_RING] |=> $stable(r.count))
      else $error("linear counter moved past upper limit");
   AST_Z_RESET: assert property (
      ce && zr && !bus_cw |=> r.count == 32'h0)
      else $error("z reset did not clear count");
   AST_REVERSE: assert property (
      ce && r.ctrl[F_REV] && !kill && !bus_cw && do_dn
      && $signed(r.count) > $signed(r.lower)
      |=> r.count == $past(r.count) - 32'h1)
      else $error("reverse step did not decrement");
   AST_ENABLE: assert property (
      ce && r.ctrl[F_C0 +: 3] == 3'h1 && !r.flt[3] && !kill && !bus_cw
      |=> $stable(r.count))
      else $error("count moved while disabled");
   AST_CAP_REFUSE: assert property (
      ce && r.capsel == 3'h1 && r.ctrl[F_C0 +: 3] != 3'h0
      |=> $stable(r.capv))
      else $error("capture taken from enable control");
   AST_OUT_FOLLOW: assert property (
      ce && r.ctrl[F_OE] && r.ctrl[F_MODE +: 2] != MD_BAND
      |=> ext_out[0] == $past(r.flags[r.osel[3:0]]))
      else $error("output does not follow its flag");
   AST_HOLD: assert property (
      ce && $rose(ext_out[0]) && r.ctrl[F_OE]
      && r.ctrl[F_MODE +: 2] == MD_BAND && r.hold[9:0] != 10'h0
      |-> ext_out[0] [*8])
      else $error("band output not held on");
   AST_BAND: assert property (
      ce && r.ctrl[F_MODE +: 2] == MD_BAND
      && $signed(r.lo[0]) <= $signed(r.count)
      && $signed(r.count) <= $signed(r.up[0])
      |=> r.flags[0] == $past(r.bandon[0]))
      else $error("band flag wrong inside band");
   AST_MATCH_RST: assert property (
      ce && mr && !bus_cw |=> r.count == 32'h0)
      else $error("match edge did not reset count");
endmodule // hsc_top

// File: sim/hsc_enc.sv
// partner model: incremental encoder giving quadrature a and b phases
`timescale 1ns/1ns
module hsc_enc (
   // clock the edges are timed from
   input  wire logic hclk,
   // quadrature lines
   output logic      a,
   output logic      b
);
   // ===========================================================
   // idle level: both phases low between cycles
   initial begin
      a = 1'b0;
      b = 1'b0;
   end
   // one full cycle of four edges, gap clocks apart
   // gap must outlast the a/b filter or the edges are swallowed
   task automatic cycle(input bit up, input int gap);
      logic x;
      logic y;
      for (int k = 0; k < 4; k++) begin
         x = (k < 2);
         y = (k == 1 || k == 2);
         repeat (gap) @(posedge hclk);
         a <= up ? x : y;
         b <= up ? y : x;
      end
   endtask
endmodule // hsc_enc

// File: sim/hsc_top_tb.sv
// testbench: counter channel driven over the bus and by the encoder
`timescale 1ns/1ns
module hsc_top_tb;
   import hsc_pkg::*;
   // ===========================================================
   // bus, pins and bookkeeping
   logic         hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0]  haddr, hwdata, hrdata, rd;
   logic [1:0]   htrans, ext_out;
   logic [2:0]   hsize;
   logic         a, b, z, c0, c1;
   hsc_pins_type pins;
   int           mismatches, samples_checked, n, m;
   logic [11:0]  ra [6] = '{A_CTRL, A_FILT, A_UPPER, A_LOWER, A_COUNT,
                            12'h0FC};
   logic [31:0]  rv [6] = '{CTRL_RST, FILT_RST, UPPER_RST, LOWER_RST,
                            32'h0, 32'h0};
   assign pins = {c1, c0, z, b, a};
   hsc_top i_hsc_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .pins(pins), .ext_out(ext_out));
   hsc_enc i_hsc_enc (.hclk(hclk), .a(a), .b(b));
   // ===========================================================
   // closing report, the single end of the run
   task automatic print_verdict();
      $display("checked %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // bounded wait for hready high at a rising edge
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 100);
      if (hreadyout !== 1'b1) begin
         mismatches++;
         print_verdict();
      end
   endtask
   // one single word transfer; read data lands in rd
   task automatic bus(input bit w, input logic [11:0] ad,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= 32'(ad);
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      wait_rdy();
      rd = hrdata;
   endtask
   // expected count after n up and m down cycles
   function automatic logic [31:0] exp_cnt(int mul, int n, int m, bit rev);
      return 32'(mul * (n - m) * (rev ? -1 : 1));
   endfunction
   // ===========================================================
   // clock
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   // ===========================================================
   // main sequence
   initial begin
      {hresetn, hsel, hwrite, z, c0, c1} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'h2;
      mismatches = 0;
      samples_checked = 0;
      void'($urandom(32'h9980));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      // reset values, unmapped place reads zero
      for (int i = 0; i < 6; i++) begin
         bus(1'b0, ra[i], 32'h0);
         chk("reset value", rv[i], rd);
      end
      chk("hresp", 32'h0, {31'h0, hresp});
      $display("reset values done");
      // fastest a/b filter, no z or control filter
      bus(1'b1, A_FILT, 32'h0);
      // two-phase x1, x2, x4, reverse on alternate runs
      for (int k = 0; k < 3; k++) begin
         n = 1 + int'($urandom % 6);
         m = int'($urandom % (n + 1));
         bus(1'b1, A_CTRL, (32'(k) << F_METH) | (32'(k % 2) << F_REV));
         bus(1'b1, A_COUNT, 32'h0);
         repeat (n) i_hsc_enc.cycle(1'b1, 30);
         repeat (m) i_hsc_enc.cycle(1'b0, 30);
         repeat (40) @(posedge hclk);
         bus(1'b0, A_COUNT, 32'h0);
         chk("count", exp_cnt(1 << k, n, m, k % 2), rd);
      end
      $display("decode done");
      // internal 1 us ticks: ten ticks in 1250 clocks, one either way
      bus(1'b1, A_CTRL, 32'h2 << F_SRC);
      bus(1'b1, A_COUNT, 32'h0);
      repeat (1250) @(posedge hclk);
      bus(1'b0, A_COUNT, 32'h0);
      chk("tick window", 32'h1, 32'(rd >= 9 && rd <= 11));
      $display("internal tick done");
      // control 0 high enable gates ticks; capture from it refused
      bus(1'b1, A_CAP, 32'h1);
      bus(1'b1, A_CTRL, (32'h2 << F_SRC) | (32'h1 << F_C0));
      bus(1'b1, A_COUNT, 32'h7);
      repeat (300) @(posedge hclk);
      bus(1'b0, A_COUNT, 32'h0);
      chk("disabled count", 32'h7, rd);
      c0 <= 1'b1;
      repeat (300) @(posedge hclk);
      bus(1'b0, A_CAPV, 32'h0);
      chk("capture refused", 32'h0, rd);
      bus(1'b0, A_COUNT, 32'h0);
      chk("enabled count", 32'h1, 32'(rd > 32'h7));
      $display("control enable done");
      // z rising edge: reset, then preset
      bus(1'b1, A_DFLT, 32'h2);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, A_CTRL, 32'(1 + 4 * k) << F_ZF);
         bus(1'b1, A_COUNT, 32'h3);
         z <= 1'b1;
         repeat (10) @(posedge hclk);
         z <= 1'b0;
         repeat (10) @(posedge hclk);
         bus(1'b0, A_COUNT, 32'h0);
         chk("z action", 32'(2 * k), rd);
      end
      $display("z input done");
      // linear stops at upper, ring wraps to lower
      bus(1'b1, A_UPPER, 32'h5);
      bus(1'b1, A_LOWER, 32'hFFFF_FFFD);
      for (int r = 0; r < 2; r++) begin
         bus(1'b1, A_CTRL, 32'(r) | (32'(M_P4) << F_METH));
         bus(1'b1, A_COUNT, 32'h4);
         i_hsc_enc.cycle(1'b1, 30);
         repeat (40) @(posedge hclk);
         bus(1'b0, A_COUNT, 32'h0);
         chk("limit", r ? 32'hFFFF_FFFF : 32'h5, rd);
      end
      $display("limits done");
      // target 3 reached counting up sets flag 0, routed to output 0
      bus(1'b1, 12'h208, 32'h3);
      bus(1'b1, 12'h20C, 32'h1);
      bus(1'b1, A_OSEL, 32'h0);
      bus(1'b1, A_COUNT, 32'h0);
      bus(1'b1, A_CTRL, (32'(MD_TGT) << F_MODE) | (32'h1 << F_OE)
                        | (32'(M_P4) << F_METH));
      i_hsc_enc.cycle(1'b1, 30);
      repeat (40) @(posedge hclk);
      bus(1'b0, A_STAT, 32'h0);
      chk("match flag", 32'h1, {31'h0, rd[0]});
      chk("output", 32'h1, {30'h0, ext_out});
      $display("target match done");
      // band 0..10, flag on inside; output held 1 ms once it turns on
      bus(1'b1, 12'h200, 32'h0);
      bus(1'b1, 12'h204, 32'hA);
      bus(1'b1, A_BANDON, 32'h1);
      bus(1'b1, A_HOLD, 32'h1);
      bus(1'b1, A_COUNT, 32'h14);
      bus(1'b1, A_CTRL, (32'(MD_BAND) << F_MODE) | (32'h1 << F_OE));
      repeat (4) @(posedge hclk);
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, A_COUNT, k ? 32'h14 : 32'h5);
         repeat (4) @(posedge hclk);
         bus(1'b0, A_STAT, 32'h0);
         chk("band flag", 32'(1 - k), {31'h0, rd[0]});
         chk("band output", 32'h1, {31'h0, ext_out[0]});
      end
      // flag 0 falling edge resets the count
      bus(1'b1, A_MRST, 32'h1_0000);
      bus(1'b1, A_COUNT, 32'h5);
      repeat (4) @(posedge hclk);
      bus(1'b1, A_COUNT, 32'h14);
      repeat (6) @(posedge hclk);
      bus(1'b0, A_COUNT, 32'h0);
      chk("match reset", 32'h0, rd);
      $display("band done");
      print_verdict();
   end
endmodule // hsc_top_tb
